// file: design/ist_timer.sv
// interval / square-wave timer: 16-bit counter, compare clear, toggle output,
// timer input routing and port-0 direction register
// assumes a single 40 MHz clock, synchronous reset and a one-cycle strobe bus
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ist_defines.svh"

module ist_timer
	import ist_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// timer input pins (asynchronous)
	input  wire logic        timer_input_a,
	input  wire logic        alt_port12_pin1,
	// timer output and port-0 direction
	output logic             timer_output_pin,
	output logic      [2:0]  port0_dir_out,
	// compare-match interrupt requests, one cycle each
	output logic             first_match_irq,
	output logic             second_match_irq
);
	ist_state_t   st_r;
	ist_state_t   st_nxt;
	logic         sync1_r;
	logic         sync2_r;
	logic         pin_sel;
	logic         tick;
	logic         edge_ok;
	logic         rise;
	logic         fall;
	ist_clk_sel_t csel;
	ist_bus_req_t req;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// pick the input pin, then synchronise it through two flops
	assign pin_sel = st_r.alt[`IST_ALT_ROUTE_BIT] ? alt_port12_pin1 : timer_input_a;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= pin_sel;
			sync2_r <= sync1_r;
		end
	end

	assign csel = ist_clk_sel_t'(st_r.prm[1:0]);
	// an edge counts once the new level is seen twice in a row
	assign rise = st_r.pin_hist[1] & st_r.pin_hist[0] & ~st_r.pin_hist[2];
	assign fall = ~st_r.pin_hist[1] & ~st_r.pin_hist[0] & st_r.pin_hist[2];

	always_comb begin
		unique case (st_r.prm[`IST_ES0_LSB +: 2])
			2'b00:   edge_ok = fall;
			2'b01:   edge_ok = rise;
			2'b11:   edge_ok = rise | fall;
			default: edge_ok = 1'b0;
		endcase
	end

	always_comb begin
		unique case (csel)
			IST_CLK_FULL:   tick = 1'b1;
			IST_CLK_DIV4:   tick = (st_r.pre[1:0] == `IST_DIV4);
			IST_CLK_DIV256: tick = (st_r.pre == `IST_DIV256);
			IST_CLK_PIN:    tick = edge_ok;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.irq1 = 1'b0;
		st_nxt.irq2 = 1'b0;
		st_nxt.rdata = 8'h00;
		st_nxt.pin_hist = {st_r.pin_hist[1:0], sync2_r};
		st_nxt.pre = st_r.pre + 8'h01;

		if (st_r.mode == IST_MODE_STOP) begin
			st_nxt.cnt = `IST_CNT_ZERO;
			st_nxt.pre = 8'h00;
		end else if (tick) begin
			if (st_r.mode == IST_MODE_CMP && st_r.cnt == st_r.cmp1) begin
				st_nxt.cnt = `IST_CNT_ZERO;
				st_nxt.irq1 = 1'b1;
				if (st_r.toc[`IST_TOC_TOGGLE_BIT]) begin
					st_nxt.tout = ~st_r.tout;
				end
			end else begin
				st_nxt.cnt = st_r.cnt + 16'h0001;
				if (st_r.mode != IST_MODE_CMP && st_r.cnt == st_r.cmp1) begin
					st_nxt.irq1 = 1'b1;
				end
			end
			if (st_r.cnt == st_r.cmp2) begin
				st_nxt.irq2 = 1'b1;
			end
		end

		if (req.wr) begin
			if (hit(req.addr, `IST_OFF_DIR)) begin
				st_nxt.dir = req.wdata | `IST_DIR_FIXED;
			end
			if (hit(req.addr, `IST_OFF_ALT)) begin
				st_nxt.alt = req.wdata & `IST_ALT_MASK;
			end
			if (hit(req.addr, `IST_OFF_PRM)) begin
				st_nxt.prm = req.wdata & `IST_PRM_MASK;
			end
			if (hit(req.addr, `IST_OFF_TMC)) begin
				st_nxt.mode = ist_mode_t'(req.wdata[`IST_TMC_MODE_LSB +: 2]);
			end
			if (hit(req.addr, `IST_OFF_TOC)) begin
				st_nxt.toc = req.wdata & `IST_TOC_MASK;
			end
			if (hit(req.addr, `IST_OFF_CMP1)) begin
				st_nxt.cmp1[7:0] = req.wdata;
			end
			if (hit(req.addr, `IST_OFF_CMP1 + 16'h0001)) begin
				st_nxt.cmp1[15:8] = req.wdata;
			end
			if (hit(req.addr, `IST_OFF_CMP2)) begin
				st_nxt.cmp2[7:0] = req.wdata;
			end
			if (hit(req.addr, `IST_OFF_CMP2 + 16'h0001)) begin
				st_nxt.cmp2[15:8] = req.wdata;
			end
			if (hit(req.addr, `IST_OFF_STAT)) begin
				st_nxt.st1 = st_r.st1 & ~req.wdata[0];
				st_nxt.st2 = st_r.st2 & ~req.wdata[1];
			end
		end
		// sticky match flags: set wins over a clear in the same cycle
		if (st_nxt.irq1) begin
			st_nxt.st1 = 1'b1;
		end
		if (st_nxt.irq2) begin
			st_nxt.st2 = 1'b1;
		end

		if (req.rd) begin
			if (hit(req.addr, `IST_OFF_DIR)) begin
				st_nxt.rdata = st_r.dir;
			end else if (hit(req.addr, `IST_OFF_ALT)) begin
				st_nxt.rdata = st_r.alt & `IST_ALT_MASK;
			end else if (hit(req.addr, `IST_OFF_PRM)) begin
				st_nxt.rdata = st_r.prm;
			end else if (hit(req.addr, `IST_OFF_TMC)) begin
				st_nxt.rdata = {4'h0, st_r.mode, 2'b00};
			end else if (hit(req.addr, `IST_OFF_TOC)) begin
				st_nxt.rdata = st_r.toc;
			end else if (hit(req.addr, `IST_OFF_CNT)) begin
				st_nxt.rdata = st_r.cnt[7:0];
			end else if (hit(req.addr, `IST_OFF_CNT + 16'h0001)) begin
				st_nxt.rdata = st_r.cnt[15:8];
			end else if (hit(req.addr, `IST_OFF_CMP1)) begin
				st_nxt.rdata = st_r.cmp1[7:0];
			end else if (hit(req.addr, `IST_OFF_CMP1 + 16'h0001)) begin
				st_nxt.rdata = st_r.cmp1[15:8];
			end else if (hit(req.addr, `IST_OFF_CMP2)) begin
				st_nxt.rdata = st_r.cmp2[7:0];
			end else if (hit(req.addr, `IST_OFF_CMP2 + 16'h0001)) begin
				st_nxt.rdata = st_r.cmp2[15:8];
			end else if (hit(req.addr, `IST_OFF_STAT)) begin
				st_nxt.rdata = {5'h00, st_r.tout, st_r.st2, st_r.st1};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_r      <= '0;
			st_r.dir  <= `IST_DIR_RST;
			st_r.alt  <= `IST_ALT_RST;
			st_r.prm  <= `IST_PRM_RST;
			st_r.mode <= IST_MODE_STOP;
			st_r.toc  <= `IST_TOC_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata        = st_r.rdata;
	assign timer_output_pin = st_r.toc[`IST_TOC_OE_BIT] & st_r.tout;
	assign port0_dir_out    = st_r.dir[2:0];
	assign first_match_irq  = st_r.irq1;
	assign second_match_irq = st_r.irq2;
endmodule : ist_timer
`default_nettype wire

// file: design/ist_defines.svh
// interval / square-wave timer: register offsets, field positions, reset values
// assumes inclusion by the timer module only
`ifndef IST_DEFINES_SVH
`define IST_DEFINES_SVH

`define IST_AW              16
`define IST_OFF_DIR         16'hff20
`define IST_OFF_ALT         16'hff39
`define IST_OFF_PRM         16'hffbb
`define IST_OFF_TMC         16'hff70
`define IST_OFF_TOC         16'hff71
`define IST_OFF_CNT         16'hff72
`define IST_OFF_CMP1        16'hff74
`define IST_OFF_CMP2        16'hff76
`define IST_OFF_STAT        16'hff78

`define IST_DIR_RST         8'hff
`define IST_DIR_FIXED       8'hf8
`define IST_ALT_RST         8'h00
`define IST_ALT_MASK        8'h50
`define IST_ALT_ROUTE_BIT   4
`define IST_PRM_RST         8'h00
`define IST_PRM_MASK        8'hf3
`define IST_TMC_RST         8'h00
`define IST_TMC_MODE_LSB    2
`define IST_TOC_RST         8'h00
`define IST_TOC_MASK        8'h13
`define IST_TOC_TOGGLE_BIT  1
`define IST_TOC_OE_BIT      0
`define IST_ES0_LSB         4
`define IST_CNT_ZERO        16'h0000
`define IST_DIV4            2'h3
`define IST_DIV256          8'hff

`endif

// file: design/ist_pkg.sv
// interval / square-wave timer: shared types
// assumes ist_defines.svh is on the include path
package ist_pkg;
	typedef enum logic [1:0] {
		IST_CLK_FULL  = 2'b00,
		IST_CLK_DIV4  = 2'b01,
		IST_CLK_DIV256 = 2'b10,
		IST_CLK_PIN   = 2'b11
	} ist_clk_sel_t;

	typedef enum logic [1:0] {
		IST_MODE_STOP = 2'b00,
		IST_MODE_FREE = 2'b01,
		IST_MODE_EDGE = 2'b10,
		IST_MODE_CMP  = 2'b11
	} ist_mode_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} ist_bus_req_t;

	typedef struct packed {
		logic [7:0]  dir;
		logic [7:0]  alt;
		logic [7:0]  prm;
		ist_mode_t   mode;
		logic [7:0]  toc;
		logic [15:0] cnt;
		logic [15:0] cmp1;
		logic [15:0] cmp2;
		logic [7:0]  pre;
		logic [2:0]  pin_hist;
		logic        tout;
		logic        irq1;
		logic        irq2;
		logic        st1;
		logic        st2;
		logic [7:0]  rdata;
	} ist_state_t;
endpackage : ist_pkg

// file: testbench/ist_timer_sva.sv
// checker: port relations of the interval timer
// assumes binding onto ist_timer, one mclk domain
`timescale 1ns/1ps
`default_nettype none
module ist_timer_sva (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        timer_output_pin,
	input wire logic [2:0]  port0_dir_out,
	input wire logic        first_match_irq,
	input wire logic        second_match_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_irq_single: assert property (first_match_irq |=> !first_match_irq)
		else $error("match pulse too long");
	a_irq2_single: assert property (second_match_irq |=> !second_match_irq)
		else $error("second match pulse too long");
	a_out_cause: assert property ($changed(timer_output_pin) |->
		first_match_irq || $past(first_match_irq) || $past(reg_wr) || $past(reg_wr, 2))
		else $error("output moved without match");
	a_dir_hold: assert property (!$past(reg_wr) |-> $stable(port0_dir_out))
		else $error("direction moved");
	a_dir_write: assert property (reg_wr && reg_addr == 16'hff20 |=>
		{5'h1f, port0_dir_out} == ($past(reg_wdata) | 8'hf8))
		else $error("direction write lost");
	a_dir_read: assert property (reg_rd && reg_addr == 16'hff20 |=>
		reg_rdata == {5'h1f, $past(port0_dir_out)})
		else $error("direction readback");
	a_out_off: assert property (reg_wr && reg_addr == 16'hff71 && !reg_wdata[0] |->
		##2 (!timer_output_pin) [*4])
		else $error("output not held low");
	a_stop_quiet: assert property (reg_wr && reg_addr == 16'hff70 && reg_wdata[3:2] == 2'b00 |->
		##2 (!first_match_irq) [*8])
		else $error("match while stopped");
endmodule : ist_timer_sva
bind ist_timer ist_timer_sva sva_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.timer_output_pin(timer_output_pin), .port0_dir_out(port0_dir_out),
	.first_match_irq(first_match_irq), .second_match_irq(second_match_irq));
`default_nettype wire

// file: testbench/interval_squarewave_timer16_test.sv
// testbench: registers, interval timing, square wave, pin-clocked counting
// assumes ist_timer compiled first; mclk 40 MHz
`timescale 1ns/1ps
`default_nettype none
module interval_squarewave_timer16_test;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        pin_a = 1'b0;
	logic        pin_alt = 1'b0;
	logic [7:0]  reg_rdata;
	logic        tout, irq1, irq2, o0;
	logic [2:0]  dir;
	logic [7:0]  rv;
	int          miscompares = 0;
	int          checks_done = 0;
	int          n, n2 = 0;
	int          dv [3] = '{1, 4, 256};
	// rows: address, write data, readback
	logic [31:0] rows [4] = '{32'hff20_00f8, 32'hff20_05fd, 32'hff39_ff50, 32'hff39_1010};
	ist_timer dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_input_a(pin_a), .alt_port12_pin1(pin_alt), .timer_output_pin(tout),
		.port0_dir_out(dir), .first_match_irq(irq1), .second_match_irq(irq2));
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) if (irq2 === 1'b1) n2++;
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_irq(output int c);
		c = 0;
		do begin
			@(posedge mclk);
			#1 c++;
		end while (irq1 !== 1'b1 && c < 3000);
	endtask : wait_irq
	// pulses of four cycles high, well above two sampling periods
	task automatic pulses(input logic on_alt, input int k);
		repeat (k) begin
			@(posedge mclk);
			if (on_alt) pin_alt <= 1'b1; else pin_a <= 1'b1;
			repeat (4) @(posedge mclk);
			pin_a   <= 1'b0;
			pin_alt <= 1'b0;
			repeat (6) @(posedge mclk);
		end
	endtask : pulses
	task automatic stop_test;
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#(25 * 40000);
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(16'hff20);
		chk(16'(rv), 16'h00ff);
		rd(16'hff39);
		chk(16'(rv), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			wr(rows[i][31:16], rows[i][15:8]);
			rd(rows[i][31:16]);
			chk(16'(rv), 16'(rows[i][7:0]));
		end
		wr(16'hff74, 8'h03);
		wr(16'hff75, 8'h00);
		wr(16'hff76, 8'h02);
		for (int s = 0; s < 3; s++) begin
			wr(16'hffbb, 8'(s));
			wr(16'hff71, s[0] ? 8'h01 : 8'h03);
			wr(16'hff70, 8'h0c);
			wait_irq(n);
			o0 = tout;
			wait_irq(n);
			chk(16'(n), 16'(4 * dv[s]));
			chk(16'(tout), 16'(s[0] ? o0 : !o0));
			wr(16'hff70, 8'h00);
			rd(16'hff72);
			chk(16'(rv), 16'h0000);
		end
		chk(16'(n2 > 0), 16'h0001);
		rd(16'hff78);
		chk(16'(rv[1:0]), 16'h0003);
		wr(16'hff78, 8'h03);
		rd(16'hff78);
		chk(16'(rv[1:0]), 16'h0000);
		wr(16'hff71, 8'h00);
		repeat (3) @(posedge mclk);
		chk(16'(tout), 16'h0000);
		wr(16'hff74, 8'h40);
		wr(16'hffbb, 8'h03);
		wr(16'hff70, 8'h0c);
		pulses(1'b0, 2);
		pulses(1'b1, 3);
		rd(16'hff72);
		chk(16'(rv), 16'h0003);
		wr(16'hff39, 8'h00);
		pulses(1'b1, 2);
		pulses(1'b0, 1);
		rd(16'hff72);
		chk(16'(rv), 16'h0004);
		wr(16'hff70, 8'h00);
		// reset in mid-run, then rising-edge pin counting from reset state
		sys_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(16'hff20);
		chk(16'(rv), 16'h00ff);
		chk(16'(dir), 16'h0007);
		wr(16'hff74, 8'h40);
		wr(16'hffbb, 8'h13);
		wr(16'hff70, 8'h0c);
		pulses(1'b0, 2);
		rd(16'hff72);
		chk(16'(rv), 16'h0002);
		wr(16'hff70, 8'h00);
		stop_test();
	end
endmodule : interval_squarewave_timer16_test
`default_nettype wire
